// >>> verilog/ais_input_select.sv
// Channel 0 input selection, input scan and pin analog/digital control
//
// Summary of operation
// - Sample A positive select n routes analog input n, 0 to 31.
// - Sample B positive select, bits 12-8, uses the Sample A encoding.
// - Sample A negative bit 7: set picks input 1, clear picks ref.
// - Sample B negative bit 15 acts like bit 7 during Sample B.
// - Select register bits 14-13 and 6-5 ignore writes, read zero.
// - Second converter can select only inputs 0 to 15 as positive.
// - Each of 32 scan bits includes its input in the scan when set.
// - All scan bits writable; missing inputs convert the low reference.
// - Digital bit set: port read enabled, mux path tied to ground.
// - Digital bit clear: analog pin, port read off, pin sampled.
// - Config bits of missing inputs read and write but do nothing.
// - Second converter has only the low pin configuration register.
// - Both converters' low config registers steer pins 0 to 15.
// - All implemented bits reset to zero, pins start analog.
// - Scan enable steps Sample A positive input through scan mask.
// - Alternate bit swaps A and B selects each sample, else A only.
`timescale 1ns/1ps
`include "ais_params.svh"

module ais_input_select #(
  parameter int NUM_INPUTS  = 32,
  parameter bit SECOND_CONV = 1'b0
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // Register port
  input  wire logic [7:0]    regAddr,
  input  wire logic [15:0]   regWrData,
  input  wire logic          regWrEn,
  input  wire logic          regRdEn,
  output logic      [15:0]   regRdData,
  // Conversion core
  input  wire logic          seqRestart,
  input  wire logic          sampleDone,
  output ais_pkg::ais_mux_t  ch0Mux,
  output logic               samplePhaseB,
  // Pins and peer converter
  input  wire logic [15:0]   peerDigitalLow,
  output logic      [15:0]   ownDigitalLow,
  output logic      [31:0]   pinDigitalMode
);

  initial begin
    if (NUM_INPUTS < 1 || NUM_INPUTS > 32) begin
      $error("ais_input_select: NUM_INPUTS must be 1 to 32");
    end
    if (SECOND_CONV && NUM_INPUTS > 16) begin
      $error("ais_input_select: second converter has at most 16 inputs");
    end
  end

  // -----------------------------------------------------------------------
  // Register port
  // -----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic [15:0] chs0_q;
  logic [15:0] scanHi_q;
  logic [15:0] scanLo_q;
  logic [15:0] pcfgHi_q;
  logic [15:0] pcfgLo_q;
  logic [15:0] ctrl_q;
  logic [15:0] regRdData_q;
  logic [15:0] rdMux;
  logic [15:0] chs0Mask;
  logic [15:0] statusWord;

  wire wrChs0   = regWrEn && hit(regAddr, `AIS_OFS_CHS0);
  wire wrScanHi = regWrEn && hit(regAddr, `AIS_OFS_SCAN_HI);
  wire wrScanLo = regWrEn && hit(regAddr, `AIS_OFS_SCAN_LO);
  wire wrPcfgHi = regWrEn && hit(regAddr, `AIS_OFS_PIN_DIGITAL_MODE_HI) && !SECOND_CONV;
  wire wrPcfgLo = regWrEn && hit(regAddr, `AIS_OFS_PIN_DIGITAL_MODE_LO);
  wire wrCtrl   = regWrEn && hit(regAddr, `AIS_OFS_CTRL);

  // Unused select bits never get stored, so reads of them return zero
  assign chs0Mask = SECOND_CONV ? `AIS_CHS0_MASK_2ND
                                : `AIS_CHS0_MASK;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chs0_q   <= `AIS_RST_VAL;
      scanHi_q <= `AIS_RST_VAL;
      scanLo_q <= `AIS_RST_VAL;
      pcfgHi_q <= `AIS_RST_VAL;
      pcfgLo_q <= `AIS_RST_VAL;
      ctrl_q   <= `AIS_RST_VAL;
    end else begin
      if (wrChs0) begin
        chs0_q <= regWrData & chs0Mask;
      end
      if (wrScanHi) begin
        scanHi_q <= regWrData;
      end
      if (wrScanLo) begin
        scanLo_q <= regWrData;
      end
      if (wrPcfgHi) begin
        pcfgHi_q <= regWrData;
      end
      if (wrPcfgLo) begin
        pcfgLo_q <= regWrData;
      end
      if (wrCtrl) begin
        ctrl_q <= regWrData & `AIS_CTRL_MASK;
      end
    end
  end

  // Unmapped offsets and the absent high register of ADC two read zero
  assign rdMux =
      hit(regAddr, `AIS_OFS_CHS0)    ? chs0_q   :
      hit(regAddr, `AIS_OFS_SCAN_HI) ? scanHi_q :
      hit(regAddr, `AIS_OFS_SCAN_LO) ? scanLo_q :
      hit(regAddr, `AIS_OFS_PIN_DIGITAL_MODE_HI) ? pcfgHi_q :
      hit(regAddr, `AIS_OFS_PIN_DIGITAL_MODE_LO) ? pcfgLo_q :
      hit(regAddr, `AIS_OFS_CTRL)    ? ctrl_q   :
      hit(regAddr, `AIS_OFS_STATUS)  ? statusWord : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdData_q <= 16'h0000;
    end else begin
      regRdData_q <= regRdEn ? rdMux : 16'h0000;
    end
  end

  assign regRdData = regRdData_q;

  // -----------------------------------------------------------------------
  // Sample phase and scan pointer
  // -----------------------------------------------------------------------
  ais_pkg::ais_phase_t phase_q;
  ais_pkg::ais_phase_t phase_d;
  logic [4:0]          scanPtr_q;
  logic [4:0]          scanPtr_d;
  logic [4:0]          searchStart;
  logic [4:0]          searchIdx;
  logic                searchFound;
  logic [31:0]         scanMask;

  wire scanEn    = ctrl_q[`AIS_SCAN_EN_BIT];
  wire altEn     = ctrl_q[`AIS_ALT_BIT];
  wire advanceA  = sampleDone && (phase_q == ais_pkg::PH_A) && scanEn;

  assign scanMask    = {scanHi_q, scanLo_q};
  assign searchStart = seqRestart ? 5'h00 : scanPtr_q + 5'h01;

  ais_scan_step #(
    .WIDTH (32),
    .IW    (5)
  ) u_scan_step (
    .mask     (scanMask),
    .startIdx (searchStart),
    .found    (searchFound),
    .idx      (searchIdx)
  );

  // Alternation restarts on Sample A; without it every sample is A
  always_comb begin
    case (phase_q)
      ais_pkg::PH_A: phase_d = (altEn && sampleDone) ? ais_pkg::PH_B
                                                     : ais_pkg::PH_A;
      ais_pkg::PH_B: phase_d = (altEn && !sampleDone) ? ais_pkg::PH_B
                                                      : ais_pkg::PH_A;
      default:       phase_d = ais_pkg::PH_A;
    endcase
    if (seqRestart) begin
      phase_d = ais_pkg::PH_A;
    end
  end

  // An empty mask leaves the pointer where it is
  assign scanPtr_d = ((seqRestart || advanceA) && searchFound) ? searchIdx
                                                              : scanPtr_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_q   <= ais_pkg::PH_A;
      scanPtr_q <= 5'h00;
    end else begin
      phase_q   <= phase_d;
      scanPtr_q <= scanPtr_d;
    end
  end

  assign statusWord = {3'h0, scanPtr_q, 7'h00, phase_q};
  assign samplePhaseB = (phase_q == ais_pkg::PH_B);

  // -----------------------------------------------------------------------
  // Pin mode
  // -----------------------------------------------------------------------
  logic [31:0] pinDigital_d;
  logic [31:0] pinDigital_q;

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_pin
      if (g >= NUM_INPUTS) begin : g_absent
        assign pinDigital_d[g] = 1'b0;
      end else if (g < 16) begin : g_shared
        // Analog wins: either converter clearing its bit keeps the pin
        assign pinDigital_d[g] = pcfgLo_q[g] & peerDigitalLow[g];
      end else begin : g_high
        assign pinDigital_d[g] = SECOND_CONV ? 1'b0 : pcfgHi_q[g-16];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pinDigital_q <= 32'h0000_0000;
    end else begin
      pinDigital_q <= pinDigital_d;
    end
  end

  assign pinDigitalMode = pinDigital_q;
  assign ownDigitalLow  = pcfgLo_q;

  // -----------------------------------------------------------------------
  // Channel 0 multiplexer
  // -----------------------------------------------------------------------
  ais_pkg::ais_mux_t mux_d;
  ais_pkg::ais_mux_t mux_q;

  wire [4:0] fixedPos = samplePhaseB ? chs0_q[`AIS_POSB_LSB +: 5]
                                     : chs0_q[`AIS_POSA_LSB +: 5];
  wire       negIn1   = samplePhaseB ? chs0_q[`AIS_NEGB_BIT]
                                     : chs0_q[`AIS_NEGA_BIT];
  wire [4:0] posIdx   = (scanEn && !samplePhaseB) ? scanPtr_q
                                                  : fixedPos;
  wire       posGone  = 32'(posIdx) >= NUM_INPUTS;

  assign mux_d.posIdx = posIdx;
  assign mux_d.posSrc = posGone              ? ais_pkg::SRC_LOWREF :
                        pinDigital_d[posIdx] ? ais_pkg::SRC_AGND   :
                                               ais_pkg::SRC_PIN;
  assign mux_d.negSrc = !negIn1        ? ais_pkg::SRC_NEGREF :
                        pinDigital_d[1] ? ais_pkg::SRC_AGND   :
                                          ais_pkg::SRC_PIN;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mux_q <= '{5'h00, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF};
    end else begin
      mux_q <= mux_d;
    end
  end

  assign ch0Mux = mux_q;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  resv_read_zero_a: assert property (
    regRdEn && hit(regAddr, `AIS_OFS_CHS0)
      |=> regRdData[14:13] == 2'b00 && regRdData[6:5] == 2'b00)
    else $error("reserved select bits read nonzero");

  pos_a_fixed_a: assert property (
    !scanEn && phase_q == ais_pkg::PH_A
      |=> ch0Mux.posIdx == $past(chs0_q[4:0]))
    else $error("sample A positive select not routed");

  pos_b_fixed_a: assert property (
    phase_q == ais_pkg::PH_B |=> ch0Mux.posIdx == $past(chs0_q[12:8]))
    else $error("sample B positive select not routed");

  neg_ref_a: assert property (
    phase_q == ais_pkg::PH_A && !chs0_q[7]
      |=> ch0Mux.negSrc == ais_pkg::SRC_NEGREF)
    else $error("negative input not on reference");

  neg_b_in1_a: assert property (
    phase_q == ais_pkg::PH_B && chs0_q[15]
      |=> ch0Mux.negSrc != ais_pkg::SRC_NEGREF)
    else $error("sample B negative input not on input 1");

  second_range_a: assert property (
    SECOND_CONV && !scanEn |-> chs0_q[12] == 1'b0 && chs0_q[4] == 1'b0)
    else $error("second converter selects above input 15");

  scan_hits_set_a: assert property (
    advanceA && searchFound && !wrScanHi && !wrScanLo
      |=> scanMask[scanPtr_q])
    else $error("scan pointer landed on skipped input");

  scan_drives_a: assert property (
    scanEn && phase_q == ais_pkg::PH_A |=> ch0Mux.posIdx == $past(scanPtr_q))
    else $error("scan pointer not driving sample A");

  lowref_a: assert property (
    posGone |=> ch0Mux.posSrc == ais_pkg::SRC_LOWREF)
    else $error("missing input not converting low reference");

  shared_pin_a: assert property (
    ##1 pinDigitalMode[0] == ($past(pcfgLo_q[0]) & $past(peerDigitalLow[0]))
        || NUM_INPUTS < 1)
    else $error("shared pin mode not combined");

  alt_toggle_a: assert property (
    altEn && sampleDone && !seqRestart |=> phase_q != $past(phase_q))
    else $error("alternation did not swap sample selects");

  no_alt_a: assert property (
    !altEn |=> phase_q == ais_pkg::PH_A)
    else $error("sample B used without alternation");

  pins_reset_a: assert property (
    $rose(rst_n) |-> pinDigitalMode == 32'h0000_0000)
    else $error("pins not analog after reset");

  scan_run_c: cover property (advanceA ##1 advanceA);
  alt_run_c:  cover property (altEn && sampleDone ##1 samplePhaseB);
  ground_c:   cover property (ch0Mux.posSrc == ais_pkg::SRC_AGND);
  lowref_c:   cover property (ch0Mux.posSrc == ais_pkg::SRC_LOWREF);

endmodule

// >>> verilog/ais_params.svh
// Offsets, field positions and reset values of the input select block
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH

// -----------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------
`define AIS_OFS_CHS0      8'h00
`define AIS_OFS_SCAN_HI   8'h04
`define AIS_OFS_SCAN_LO   8'h08
`define AIS_OFS_PIN_DIGITAL_MODE_HI   8'h0C
`define AIS_OFS_PIN_DIGITAL_MODE_LO   8'h10
`define AIS_OFS_CTRL      8'h14
`define AIS_OFS_STATUS    8'h18

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define AIS_POSA_LSB      0
`define AIS_NEGA_BIT      7
`define AIS_POSB_LSB      8
`define AIS_NEGB_BIT      15
`define AIS_SCAN_EN_BIT   10
`define AIS_ALT_BIT       0
`define AIS_STAT_PHASE    0
`define AIS_STAT_PTR_LSB  8

// -----------------------------------------------------------------------
// Write masks and reset values
// -----------------------------------------------------------------------
`define AIS_CHS0_MASK     16'h9F9F
`define AIS_CHS0_MASK_2ND 16'h8F8F
`define AIS_CTRL_MASK     16'h0401
`define AIS_RST_VAL       16'h0000

`endif

// >>> verilog/ais_pkg.sv
// Types shared by the converter input select block
package ais_pkg;

  typedef enum logic {
    PH_A = 1'b0,
    PH_B = 1'b1
  } ais_phase_t;

  typedef enum logic [1:0] {
    SRC_PIN    = 2'b00,
    SRC_AGND   = 2'b01,
    SRC_LOWREF = 2'b11,
    SRC_NEGREF = 2'b10
  } ais_src_t;

  typedef struct packed {
    logic [4:0] posIdx;
    ais_src_t   posSrc;
    ais_src_t   negSrc;
  } ais_mux_t;

endpackage

// >>> verilog/ais_scan_step.sv
// Circular search for the next set bit of the scan mask
`timescale 1ns/1ps

module ais_scan_step #(
  parameter int WIDTH = 32,
  parameter int IW    = 5
) (
  // Search request
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic [IW-1:0]    startIdx,
  // Result
  output logic                  found,
  output logic [IW-1:0]         idx
);

  initial begin
    if (WIDTH != (1 << IW)) begin
      $error("ais_scan_step: WIDTH must be 2**IW");
    end
  end

  logic [2*WIDTH-1:0] doubled;
  logic [WIDTH-1:0]   rotated;
  logic [IW-1:0]      offset;

  assign doubled = {mask, mask} >> startIdx;
  assign rotated = doubled[WIDTH-1:0];
  assign found   = |mask;

  // Lowest set bit of the rotated mask; wraps for free as IW bits
  always_comb begin
    offset = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (rotated[i]) begin
        offset = IW'(i);
      end
    end
  end

  assign idx = startIdx + offset;

endmodule

// >>> sim/ais_input_select_tb.sv
// Self-checking bench for the converter input select block
`timescale 1ns/1ps

module ais_input_select_tb;
  // -------------------------------------------------------------------
  // Signals and expectation queues
  // -------------------------------------------------------------------
  typedef struct packed {
    ais_pkg::ais_mux_t mux;
    logic              phB;
    logic [31:0]       pdm;
    logic [15:0]       own;
    ais_pkg::ais_src_t src2;
  } ais_note_t;

  logic              clk_sys        = 1'b0;
  logic              rst_n          = 1'b0;
  logic [7:0]        regAddr        = 8'h00;
  logic [15:0]       regWrData      = 16'h0000;
  logic              regWrEn        = 1'b0;
  logic              regRdEn        = 1'b0;
  logic              seqRestart     = 1'b0;
  logic              sampleDone     = 1'b0;
  logic [15:0]       peerDigitalLow = 16'hFFFF;
  logic              probe          = 1'b0;
  logic              rdSeen         = 1'b0;
  logic [15:0]       regRdData;
  ais_pkg::ais_mux_t ch0Mux;
  logic              samplePhaseB;
  logic [15:0]       ownDigitalLow;
  logic [31:0]       pinDigitalMode;
  logic [15:0]       rdData2;
  ais_pkg::ais_mux_t mux2;
  logic [31:0]       pdm2;
  logic [15:0]       expOwn         = 16'h0000;
  ais_pkg::ais_src_t expSrc2        = ais_pkg::SRC_PIN;
  logic [31:0]       rdQ[$];
  logic [31:0]       rdNote;
  ais_note_t         muxQ[$];
  ais_note_t         noteNow;
  logic [31:0]       rng            = 32'h0000_0020;
  logic [15:0]       v;
  int                err_count      = 0;
  int                check_count    = 0;

  always #5 clk_sys = ~clk_sys;

  ais_input_select #(
    .NUM_INPUTS (32),
    .SECOND_CONV(1'b0)
  ) u_dut (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWrEn       (regWrEn),
    .regRdEn       (regRdEn),
    .regRdData     (regRdData),
    .seqRestart    (seqRestart),
    .sampleDone    (sampleDone),
    .ch0Mux        (ch0Mux),
    .samplePhaseB  (samplePhaseB),
    .peerDigitalLow(peerDigitalLow),
    .ownDigitalLow (ownDigitalLow),
    .pinDigitalMode(pinDigitalMode)
  );

  // Second converter shares the bus and sees the same peer pin config
  ais_input_select #(
    .NUM_INPUTS (16),
    .SECOND_CONV(1'b1)
  ) u_dut2 (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWrEn       (regWrEn),
    .regRdEn       (regRdEn),
    .regRdData     (rdData2),
    .seqRestart    (seqRestart),
    .sampleDone    (sampleDone),
    .ch0Mux        (mux2),
    .samplePhaseB  (),
    .peerDigitalLow(peerDigitalLow),
    .ownDigitalLow (),
    .pinDigitalMode(pdm2)
  );

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  function logic [15:0] rnd16();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction

  function automatic ais_pkg::ais_mux_t mk(input logic [4:0] i,
      input ais_pkg::ais_src_t p, input ais_pkg::ais_src_t n);
    return '{posIdx: i, posSrc: p, negSrc: n};
  endfunction

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      regWrEn    <= 1'b0;
      regRdEn    <= 1'b0;
      seqRestart <= 1'b0;
      sampleDone <= 1'b0;
      probe      <= 1'b0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    regRdEn   <= 1'b0;
    if (a == 8'h10) expOwn = d;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    regWrEn <= 1'b0;
    // Second converter drops select bits 12 and 4 and has no high config
    rdQ.push_back({(a == 8'h0C) ? 16'h0000 :
                   (a == 8'h00) ? (e & 16'h8F8F) : e, e});
  endtask

  // One-cycle event from the conversion core
  task evt(input logic done);
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    if (done) sampleDone <= 1'b1;
    else seqRestart <= 1'b1;
    idle(1);
  endtask

  // Settle time covers the one-cycle mux latency with margin
  task chk(input ais_pkg::ais_mux_t m, input logic b, input logic [31:0] d);
    idle(3);
    @(posedge clk_sys);
    probe <= 1'b1;
    muxQ.push_back('{mux: m, phB: b, pdm: d, own: expOwn,
                     src2: expSrc2});
    idle(1);
  endtask

  task give_verdict();
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Output watcher
  // -------------------------------------------------------------------
  always @(posedge clk_sys) begin
    rdSeen <= regRdEn;
    if (rdSeen) begin
      rdNote = rdQ.pop_front();
      cmp("regRdData", 32'(rdNote[15:0]), 32'(regRdData));
      cmp("regRdData2", 32'(rdNote[31:16]), 32'(rdData2));
    end
    if (probe) begin
      noteNow = muxQ.pop_front();
      cmp("ch0Mux", 32'(noteNow.mux), 32'(ch0Mux));
      cmp("samplePhaseB", 32'(noteNow.phB), 32'(samplePhaseB));
      cmp("pinDigitalMode", noteNow.pdm, pinDigitalMode);
      cmp("ownDigitalLow", 32'(noteNow.own), 32'(ownDigitalLow));
      cmp("ch0Mux2.posSrc", 32'(noteNow.src2), 32'(mux2.posSrc));
      cmp("pinDigitalMode2", noteNow.pdm & 32'h0000_FFFF, pdm2);
    end
  end

  initial begin
    #300000;
    err_count++;
    give_verdict();
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rd(8'(a), 16'h0000);
    chk(mk(5'h00, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 5; j++) begin
        v = rnd16();
        wr(8'(4 * j), v);
        rd(8'(4 * j), (j == 0) ? (v & 16'h9F9F) : v);
      end
    end
    wr(8'h20, 16'hFFFF);
    rd(8'h20, 16'h0000);
    wr(8'h14, 16'hFFFF);
    rd(8'h14, 16'h0401);
    wr(8'h14, 16'h0000);
    for (int j = 1; j < 5; j++) wr(8'(4 * j), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h001F : rnd16();
      peerDigitalLow <= rnd16();
      wr(8'h00, v);
      chk(mk(v[4:0], ais_pkg::SRC_PIN,
          v[7] ? ais_pkg::SRC_PIN : ais_pkg::SRC_NEGREF), 1'b0, 0);
    end
    wr(8'h10, 16'h0003);
    wr(8'h0C, 16'h8000);
    peerDigitalLow <= 16'h0002;
    wr(8'h00, 16'h0081);
    expSrc2 = ais_pkg::SRC_AGND;
    chk(mk(5'd1, ais_pkg::SRC_AGND, ais_pkg::SRC_AGND), 1'b0,
        32'h8000_0002);
    expSrc2 = ais_pkg::SRC_PIN;
    peerDigitalLow <= 16'hFFFF;
    wr(8'h00, 16'h001F);
    chk(mk(5'd31, ais_pkg::SRC_AGND, ais_pkg::SRC_NEGREF), 1'b0,
        32'h8000_0003);
    wr(8'h0C, 16'h0000);
    wr(8'h10, 16'h0000);
    chk(mk(5'd31, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    wr(8'h00, 16'h8502);
    wr(8'h14, 16'h0001);
    evt(1'b0);
    chk(mk(5'd2, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    evt(1'b1);
    chk(mk(5'd5, ais_pkg::SRC_PIN, ais_pkg::SRC_PIN), 1'b1, 0);
    evt(1'b1);
    chk(mk(5'd2, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    wr(8'h08, 16'h0006);
    wr(8'h14, 16'h0401);
    evt(1'b0);
    chk(mk(5'd1, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    evt(1'b1);
    chk(mk(5'd5, ais_pkg::SRC_PIN, ais_pkg::SRC_PIN), 1'b1, 0);
    evt(1'b1);
    chk(mk(5'd2, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    wr(8'h14, 16'h0400);
    wr(8'h08, 16'h0000);
    wr(8'h04, 16'h8000);
    expSrc2 = ais_pkg::SRC_LOWREF;
    evt(1'b0);
    chk(mk(5'd31, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    evt(1'b1);
    chk(mk(5'd31, ais_pkg::SRC_PIN, ais_pkg::SRC_NEGREF), 1'b0, 0);
    rd(8'h18, 16'h1F00);
    idle(4);
    give_verdict();
  end
endmodule
